/* eth_top.sv */
// eth_top: external event handshake, strobe in, done pulse out
// assumes keys arrive as one-cycle pulses on clk; connector lines are pins
`timescale 1ns/10ps
// Notes on behaviour
// - select key toggles continuous and external mode
// - waiting in external mode lights indicator, dashes until first event
// - manual fire key gives exactly one reading
// - default done on line one, strobe line one
// - falling edge of remote strobe is event
// - strobe ignored unless external mode selected
// - done pulse drives the output line
// - each event: one reading, stored, then done
// - after done, return to waiting point
// - scan start in external mode lights asterisk
// - programmable manual or auto delay before measuring
// - done only after whole measurement action finishes
module eth_top (
	input  wire logic                        clk,
	input  wire logic                        rst,
	input  wire logic                        ext_event_select_key,
	input  wire logic                        manual_fire_key,
	input  wire logic                        scan_start,
	input  wire logic                        scan_stop,
	input  wire logic [eth_pkg::IN_LINES-1:0] link_in,
	output logic      [eth_pkg::OUT_LINES-1:0] link_out,
	input  wire logic [1:0]                  in_line_sel,
	input  wire logic [1:0]                  out_line_sel,
	input  wire logic                        auto_delay_en,
	input  wire logic [eth_pkg::CNT_W-1:0]   manual_delay_cyc,
	input  wire logic [eth_pkg::CNT_W-1:0]   auto_delay_cyc,
	output logic                             meas_start,
	input  wire logic                        meas_busy_done,
	output logic                             store_reading,
	output logic                             ext_mode_led,
	output logic                             dashes_show,
	output logic                             asterisk_led,
	output logic                             measurement_done_output
);
	eth_pkg::eth_state_e state_r, state_nxt;
	logic                       ext_mode_r;
	logic                       scan_r;
	logic                       seen_r;
	logic [eth_pkg::IN_LINES-1:0]  meta_r;
	logic [eth_pkg::IN_LINES-1:0]  pin_r;
	logic                       last_r;
	logic [eth_pkg::CNT_W-1:0]  dly_r;
	logic [eth_pkg::DONE_W-1:0] done_r;
	logic                       start_r;
	logic                       store_r;
	logic                       remote_strobe_input;
	logic                       strobe_fall;
	logic                       event_hit;
	logic [eth_pkg::CNT_W-1:0]  dly_load;
	logic                       done_now;
	logic                       in_wait;
	logic                       in_delay;
	logic                       in_meas;
	logic                       meas_end;
	logic                       dly_over;
	logic [eth_pkg::OUT_LINES-1:0] out_pick;

	// picks one synchronised connector line; an unused code reads as
	// idle high so that a bad strap setting can never fake a fall
	function automatic logic pick_line(
		input logic [eth_pkg::IN_LINES-1:0] lines,
		input logic [1:0]                   sel
	);
		logic bit_v;
		bit_v = 1'h1;
		for (int i = 0; i < eth_pkg::IN_LINES; i++) begin
			if (sel == 2'(i)) begin
				bit_v = lines[i];
			end
		end
		return bit_v;
	endfunction

	// every line crosses two flops before the select reads it, so a
	// change of in_line_sel never looks at an unsettled first stage
	assign remote_strobe_input = pick_line(pin_r, in_line_sel);
	assign strobe_fall = last_r & ~remote_strobe_input;
	assign in_wait  = (state_r == eth_pkg::ETH_WAIT);
	assign in_delay = (state_r == eth_pkg::ETH_DELAY);
	assign in_meas  = (state_r == eth_pkg::ETH_MEAS);
	assign meas_end = in_meas & meas_busy_done;
	assign dly_over = in_delay & (dly_r == '0);
	// edges outside the waiting state are dropped, not queued
	assign event_hit = ext_mode_r & in_wait
		& (strobe_fall | manual_fire_key);
	assign dly_load = auto_delay_en ? auto_delay_cyc
		: manual_delay_cyc;
	assign done_now = (done_r != '0);

	// the done line choice is decoded once per connector line
	for (genvar g = 0; g < eth_pkg::OUT_LINES; g++) begin : g_out
		assign out_pick[g] = (out_line_sel == 2'(g));
	end

	// one event walks wait, delay, measure and done in turn; leaving
	// external mode only takes effect back at the waiting point, so an
	// action already under way always ends with its done pulse
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			eth_pkg::ETH_IDLE: begin
				if (ext_mode_r) begin
					state_nxt = eth_pkg::ETH_WAIT;
				end
			end
			eth_pkg::ETH_WAIT: begin
				if (!ext_mode_r) begin
					state_nxt = eth_pkg::ETH_IDLE;
				end else if (event_hit) begin
					state_nxt = eth_pkg::ETH_DELAY;
				end
			end
			eth_pkg::ETH_DELAY: begin
				if (dly_r == '0) begin
					state_nxt = eth_pkg::ETH_MEAS;
				end
			end
			eth_pkg::ETH_MEAS: begin
				if (meas_busy_done) begin
					state_nxt = eth_pkg::ETH_DONE;
				end
			end
			eth_pkg::ETH_DONE: begin
				if (done_r == 8'h01) begin
					state_nxt = eth_pkg::ETH_WAIT;
				end
			end
			default: state_nxt = eth_pkg::ETH_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			// reset to the idle level: no false edge after reset
			meta_r <= '1;
			pin_r  <= '1;
			last_r <= 1'h1;
		end else begin
			meta_r <= link_in;
			pin_r  <= meta_r;
			last_r <= remote_strobe_input;
		end
	end

	// the key clears the waiting marks too, so a fresh mode entry
	// shows dashes again until its first event
	always_ff @(posedge clk) begin
		if (rst) begin
			ext_mode_r <= 1'h0;
			scan_r     <= 1'h0;
			seen_r     <= 1'h0;
		end else begin
			if (ext_event_select_key) begin
				ext_mode_r <= ~ext_mode_r;
			end
			if (scan_start) begin
				scan_r <= 1'h1;
			end else if (scan_stop) begin
				scan_r <= 1'h0;
			end
			if (scan_start | ext_event_select_key) begin
				seen_r <= 1'h0;
			end else if (event_hit) begin
				seen_r <= 1'h1;
			end
		end
	end

	// a zero delay still spends one cycle in the delay state; the
	// done pulse length is a fixed cycle count set in the package
	always_ff @(posedge clk) begin
		if (rst) begin
			state_r <= eth_pkg::ETH_IDLE;
			dly_r   <= '0;
			done_r  <= '0;
			start_r <= 1'h0;
			store_r <= 1'h0;
		end else begin
			state_r <= state_nxt;
			start_r <= dly_over;
			store_r <= meas_end;
			if (event_hit) begin
				dly_r <= dly_load;
			end else if (dly_r != '0) begin
				dly_r <= dly_r - 1'b1;
			end
			if (meas_end) begin
				done_r <= eth_pkg::DONE_W'(eth_pkg::DONE_CYC);
			end else if (done_now) begin
				done_r <= done_r - 1'b1;
			end
		end
	end

	// indicators and lines are registered so that no decode glitch
	// ever reaches a connector pin or a front panel lamp
	always_ff @(posedge clk) begin
		if (rst) begin
			link_out                <= '0;
			measurement_done_output <= 1'h0;
			ext_mode_led            <= 1'h0;
			dashes_show             <= 1'h0;
			asterisk_led            <= 1'h0;
		end else begin
			measurement_done_output <= done_now;
			link_out <= out_pick & {eth_pkg::OUT_LINES{done_now}};
			ext_mode_led <= ext_mode_r;
			dashes_show  <= ext_mode_r & ~seen_r;
			asterisk_led <= ext_mode_r & scan_r & ~seen_r;
		end
	end

	assign meas_start    = start_r;
	assign store_reading = store_r;
endmodule

/* eth_pkg.sv */
// eth_pkg: constants and state encoding for the external event handshake
// assumes one 125 MHz clock; measurement engine and keys live outside
package eth_pkg;
	localparam int unsigned CLK_MHZ       = 125;
	localparam int unsigned DONE_PULSE_NS = 1000;
	localparam int unsigned DONE_CYC      = (DONE_PULSE_NS * CLK_MHZ) / 1000;
	localparam int unsigned CNT_W         = 32;
	localparam int unsigned DONE_W        = 8;
	localparam int unsigned IN_LINES      = 3;
	localparam int unsigned OUT_LINES     = 3;
	localparam logic [1:0]  DEF_OUT_SEL   = 2'h0;
	localparam logic [1:0]  DEF_IN_SEL    = 2'h0;
	typedef enum logic [2:0] {
		ETH_IDLE  = 3'h0,
		ETH_WAIT  = 3'h1,
		ETH_DELAY = 3'h2,
		ETH_MEAS  = 3'h3,
		ETH_DONE  = 3'h4
	} eth_state_e;
endpackage

/* eth_top_sva.sv */
// eth_top_sva: port checker for eth_top
// assumes the bench binds it to eth_top with out_line_sel at 0
`timescale 1ns/10ps
module eth_top_sva (
	input wire logic       clk,
	input wire logic       rst,
	input wire logic       ext_event_select_key,
	input wire logic       meas_busy_done,
	input wire logic [2:0] link_out,
	input wire logic       meas_start,
	input wire logic       store_reading,
	input wire logic       ext_mode_led,
	input wire logic       dashes_show,
	input wire logic       measurement_done_output
);
	logic [eth_pkg::DONE_W-1:0] hi_r;
	always_ff @(posedge clk) begin
		if (rst)
			hi_r <= 8'h0;
		else
			hi_r <= measurement_done_output ? hi_r + 8'h1 : 8'h0;
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	sequence s_stored;
		$past(meas_busy_done) ##1 $rose(measurement_done_output);
	endsequence
	mode_rise_a: assert property ($rose(ext_mode_led) |->
		$past(ext_event_select_key, 2)) else $error("mode rise");
	start_ext_a: assert property (meas_start |-> ext_mode_led)
		else $error("start outside mode");
	dash_clear_a: assert property (meas_start |-> !dashes_show)
		else $error("dashes on");
	store_order_a: assert property (store_reading |-> s_stored)
		else $error("store order");
	done_width_a: assert property ($fell(measurement_done_output) |->
		hi_r == eth_pkg::DONE_CYC) else $error("done width");
	link_copy_a: assert property ((|link_out) ==
		measurement_done_output) else $error("link out");
	start_pulse_a: assert property (meas_start |=> !meas_start)
		else $error("start width");
	no_overlap_a: assert property (measurement_done_output |->
		!meas_start && !store_reading) else $error("overlap");
endmodule

/* eth_scanner.sv */
// eth_scanner: behavioural channel scanner on the far side of the link
// assumes go rises once per scan; ready_n idles high
`timescale 1ns/10ps
module eth_scanner #(parameter int CHANS = 3) (
	input  wire logic clk,
	input  wire logic go,
	input  wire logic done,
	output logic      ready_n
);
	initial ready_n = 1'b1;
	// first channel closes five cycles after go, later ones five cycles after done falls
	always begin
		@(posedge go);
		for (int c = 0; c < CHANS; c++) begin
			if (c > 0)
				@(negedge done);
			repeat (5) @(posedge clk);
			ready_n <= 1'b0; // device acts on this fall
			repeat (3) @(posedge clk);
			ready_n <= 1'b1;
		end
	end
endmodule

/* test_eth_top.sv */
// test_eth_top: self-checking bench for eth_top
// assumes the scanner model and a small engine model stand around it
`timescale 1ns/10ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin err_total++; \
	$display("unexpected t=%0t %h %h", $time, a, b); end end
module test_eth_top;
	logic clk = 0, rst = 1, ext_event_select_key = 0, manual_fire_key = 0;
	logic scan_start = 0, scan_stop = 0, auto_delay_en = 0, go = 0;
	logic meas_busy_done = 0, tb_strobe_n = 1, sc_ready_n;
	logic [1:0] in_line_sel = 2'h0, out_line_sel = 2'h0, bq = 2'h0;
	logic [31:0] manual_delay_cyc = 32'h4, auto_delay_cyc = 32'h6;
	logic [2:0] link_in, link_out;
	logic meas_start, store_reading, ext_mode_led, dashes_show;
	logic asterisk_led, measurement_done_output;
	int err_total = 0, n_checks = 0, n_st = 0, n_sr = 0;
	assign link_in = {3{tb_strobe_n & sc_ready_n}};
	eth_top uut (.*);
	eth_scanner scn (.clk(clk), .go(go), .done(measurement_done_output),
		.ready_n(sc_ready_n));
	always #4 clk = ~clk;
	// engine model: action finishes three cycles after start
	always @(posedge clk) begin
		n_st += meas_start;
		n_sr += store_reading;
		meas_busy_done <= (bq == 2'h1);
		if (meas_start)
			bq <= 2'h3;
		else if (bq != 2'h0)
			bq <= bq - 2'h1;
	end
	task tick(int n);
		repeat (n) @(posedge clk);
	endtask
	task tally_and_finish;
		$display("checks %0d errors %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task wait_sr(int k);
		for (int i = 0; i < 3000 && n_sr < k; i++) @(posedge clk);
		if (n_sr < k) begin
			err_total++;
			tally_and_finish();
		end
	endtask
	task t_ignore;
		@(posedge clk) tb_strobe_n <= 0;
		tick(3);
		tb_strobe_n <= 1;
		tick(20);
		`CHK(n_st, 0)
	endtask
	task t_mode;
		@(posedge clk) ext_event_select_key <= 1;
		@(posedge clk) ext_event_select_key <= 0;
		tick(4);
		`CHK(ext_mode_led, 1'b1)
		`CHK(dashes_show, 1'b1)
	endtask
	// a second key press during the done pulse must be dropped
	task t_fire;
		@(posedge clk) manual_fire_key <= 1;
		@(posedge clk) manual_fire_key <= 0;
		wait_sr(1);
		manual_fire_key <= 1;
		tb_strobe_n <= 0;
		@(posedge clk) manual_fire_key <= 0;
		tb_strobe_n <= 1;
		`CHK(measurement_done_output, 1'b1)
		`CHK(link_out, 3'h1)
		tick(140);
		`CHK(n_st, 1)
		`CHK(n_sr, 1)
		`CHK(dashes_show, 1'b0)
	endtask
	task t_scan;
		auto_delay_en <= 1;
		scan_start <= 1;
		@(posedge clk) scan_start <= 0;
		tick(3);
		`CHK(asterisk_led, 1'b1)
		go <= 1;
		wait_sr(4);
		tick(140);
		`CHK(n_sr, 4)
		`CHK(n_st, 4)
	endtask
	task t_leave;
		@(posedge clk) ext_event_select_key <= 1;
		@(posedge clk) ext_event_select_key <= 0;
		tick(4);
		`CHK(ext_mode_led, 1'b0)
		`CHK(dashes_show, 1'b0)
	endtask
	initial begin
		tick(4);
		rst <= 0;
		t_ignore();
		t_mode();
		t_fire();
		t_scan();
		t_leave();
		tally_and_finish();
	end
endmodule
bind eth_top eth_top_sva chk (.*);
